// *** hw/sfpi_top.sv ***
// Purpose: Pin front end of a serial NOR flash: select, clock, lanes, pause
// Assumes: Serial clock is sampled by clk and must be well below clk/4
// Notes:   Array storage lives outside; this block decodes and carries data
`timescale 1ns/1ps
module sfpi_top import sfpi_pkg::*; #(
  parameter int unsigned        DUMMY_CYCLES = FAST_DUMMY,
  parameter logic [UID_W-1:0]   UNIQUE_ID    = 128'h0123456789abcdef0123456789abcdef
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               chip_select_n,
  input  wire logic               serial_clock,
  input  wire logic [3:0]         lane_in,
  output logic      [3:0]         lane_out,
  output logic      [3:0]         lane_oe,
  input  wire sfpi_status_t       status,
  input  wire logic               array_busy,
  output sfpi_req_t               req,
  output logic                    req_valid,
  output logic                    protect_pin_blocks,
  output logic                    status_write_refused,
  output logic      [7:0]         wr_data,
  output logic                    wr_valid,
  input  wire logic               wr_ready,
  input  wire logic [7:0]         rd_data,
  input  wire logic               rd_valid,
  output logic                    rd_ready,
  output logic      [6:0]         wrap_len
);
  initial begin
    if (DUMMY_CYCLES == 0 || DUMMY_CYCLES > 15) $error("sfpi_top dummy cycles out of range");
  end

  // ***********************************************************
  // Reset and pin synchronisation
  // ***********************************************************
  logic       rst_s1;
  logic       rst_n;
  logic [5:0] pins;
  logic       cs_n_s;
  logic       sclk_s;
  logic [3:0] lane_s;
  logic       sclk_d;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  sfpi_sync #(.WIDTH(6)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({chip_select_n, ~serial_clock, ~lane_in}),
    .dout  (pins[5:0])
  );
  assign cs_n_s  = pins[5];
  assign sclk_s  = !pins[4];
  assign lane_s  = ~pins[3:0];

  // ***********************************************************
  // Link state
  // ***********************************************************
  typedef enum logic [2:0] { SF_CMD, SF_ADDR, SF_DUMMY, SF_RX, SF_TX, SF_IGNORE } sfpi_state_t;

  sfpi_state_t state, next_state;
  logic        armed, next_armed;
  logic        cs_d, next_cs_d;
  logic [7:0]  shreg, next_shreg;
  logic [4:0]  bitcnt, next_bitcnt;
  logic [7:0]  cmd, next_cmd;
  logic [23:0] addr, next_addr;
  sfpi_width_t in_w, next_in_w;
  sfpi_width_t out_w, next_out_w;
  logic        is_prog, next_is_prog;
  logic        is_uid, next_is_uid;
  logic [6:0]  uid_idx, next_uid_idx;
  logic [7:0]  txbyte, next_txbyte;
  logic [3:0]  next_lane_out, next_lane_oe;
  logic        next_tx_load;
  logic        tx_load;
  sfpi_req_t   next_req;
  logic        next_req_valid;
  logic        next_refused;
  logic [6:0]  next_wrap;
  logic        next_blocks;
  logic [7:0]  rx_byte;
  logic        rx_push;
  logic        fifo_in_ready;
  logic        rise, fall, paused, quad;
  logic [2:0]  step;

  always_comb begin
    quad   = status.quad_enable_bit;
    rise   = sclk_s && !sclk_d;
    fall   = !sclk_s && sclk_d;
    paused = !quad && !lane_s[3];
    case (state == SF_TX ? out_w : in_w)
      SFPI_W2: step = 3'd2;
      SFPI_W4: step = 3'd4;
      default: step = 3'd1;
    endcase
  end

  always_comb begin
    next_state     = state;
    next_armed     = armed;
    next_cs_d      = cs_n_s;
    next_shreg     = shreg;
    next_bitcnt    = bitcnt;
    next_cmd       = cmd;
    next_addr      = addr;
    next_in_w      = in_w;
    next_out_w     = out_w;
    next_is_prog   = is_prog;
    next_is_uid    = is_uid;
    next_uid_idx   = uid_idx;
    next_txbyte    = txbyte;
    next_lane_out  = lane_out;
    next_lane_oe   = lane_oe;
    next_tx_load   = 1'b0;
    next_req       = req;
    next_req_valid = 1'b0;
    next_refused   = 1'b0;
    next_wrap      = wrap_len;
    next_blocks    = !quad && !lane_s[2];
    rx_byte        = shreg;
    rx_push        = 1'b0;
    if (cs_n_s) begin
      next_lane_oe = 4'h0;
      next_state   = SF_CMD;
      next_bitcnt  = '0;
      next_in_w    = SFPI_W1;
      if (cs_d == 1'b0) begin
        next_armed = 1'b1;
      end else if (!armed) begin
        next_armed = 1'b1;
      end
    end else if (cs_d && !armed) begin
      next_state = SF_IGNORE;
    end else if (paused) begin
      next_lane_oe = 4'h0;
    end else if (rise && state != SF_TX && state != SF_IGNORE) begin
      case (in_w)
        SFPI_W2: next_shreg = {shreg[5:0], lane_s[1:0]};
        SFPI_W4: next_shreg = {shreg[3:0], lane_s};
        default: next_shreg = {shreg[6:0], lane_s[0]};
      endcase
      next_bitcnt = bitcnt + 5'(step);
      case (state)
        SF_CMD: begin
          if (bitcnt == 5'd7) begin
            next_cmd    = next_shreg;
            next_bitcnt = '0;
            next_state  = SF_ADDR;
            next_is_prog = 1'b0;
            next_is_uid  = 1'b0;
            next_req.security = 1'b0;
            next_req.uid      = 1'b0;
            next_out_w  = SFPI_W1;
            case (next_shreg)
              CMD_DUAL_OUT: next_out_w = SFPI_W2;
              CMD_QUAD_OUT: next_out_w = quad ? SFPI_W4 : SFPI_W1;
              CMD_DUAL_IO: begin
                next_in_w  = SFPI_W2;
                next_out_w = SFPI_W2;
              end
              CMD_QUAD_IO: begin
                next_in_w  = quad ? SFPI_W4 : SFPI_W1;
                next_out_w = quad ? SFPI_W4 : SFPI_W1;
              end
              CMD_PROGRAM, CMD_SEC_PROG: next_is_prog = 1'b1;
              CMD_QUAD_PROG: next_is_prog = quad;
              CMD_CHIP_ERS, CMD_CHIP_ERS2: begin
                next_req.op    = SFPI_OP_ERASE_CHIP;
                next_req.addr  = '0;
                next_req_valid = !array_busy;
                next_state     = SF_IGNORE;
              end
              CMD_WR_STATUS: begin
                next_state = SF_RX;
                next_refused = status.status_protect_bits[0] && next_blocks;
              end
              CMD_WRAP: next_state = SF_DUMMY;
              CMD_UID_READ: next_is_uid = 1'b1;
              default: ;
            endcase
            if (next_shreg == CMD_QUAD_PROG && quad) begin
              next_in_w = SFPI_W1;
            end
          end
        end
        SF_ADDR: begin
          next_addr = {addr[22:0], 1'b0};
          case (in_w)
            SFPI_W2: next_addr = {addr[21:0], lane_s[1:0]};
            SFPI_W4: next_addr = {addr[19:0], lane_s};
            default: next_addr = {addr[22:0], lane_s[0]};
          endcase
          if (bitcnt + 5'(step) >= 5'd24) begin
            next_bitcnt = '0;
            next_req.addr = next_addr;
            next_req.security = cmd == CMD_SEC_READ || cmd == CMD_SEC_PROG || cmd == CMD_SEC_ERS;
            next_req.uid = is_uid;
            next_state = SF_DUMMY;
            case (cmd)
              CMD_SECT_ERS: begin
                next_req.op   = SFPI_OP_ERASE_SEC;
                next_req.addr = {next_addr[23:SECTOR_LSB], 12'h000};
              end
              CMD_BLOCK_ERS: begin
                next_req.op   = SFPI_OP_ERASE_BLK;
                next_req.addr = {next_addr[23:BLOCK_LSB], 16'h0000};
              end
              CMD_SEC_ERS: begin
                next_req.op   = SFPI_OP_ERASE_SEC;
                next_req.addr = {10'h000, next_addr[SECTOR_LSB+1:SECTOR_LSB], 12'h000};
              end
              default: next_req.op = is_prog ? SFPI_OP_PROG : SFPI_OP_READ;
            endcase
            if (cmd == CMD_SECT_ERS || cmd == CMD_BLOCK_ERS || cmd == CMD_SEC_ERS) begin
              next_state     = SF_IGNORE;
              next_req_valid = !array_busy;
            end else if (is_prog) begin
              next_state = SF_RX;
              if (cmd == CMD_QUAD_PROG) begin
                next_in_w = SFPI_W4;
              end
              next_req_valid = !array_busy;
            end else if (cmd == CMD_READ) begin
              next_state     = SF_TX;
              next_req_valid = 1'b1;
            end
          end
        end
        SF_DUMMY: begin
          if (cmd == CMD_WRAP && bitcnt == 5'd7) begin
            // byte window from bits 6:5, bit 4 clear enables
            next_wrap  = next_shreg[4] ? 7'h00 : 7'(8 << next_shreg[6:5]);
            next_state = SF_IGNORE;
          end else if (cmd != CMD_WRAP && bitcnt == 5'(DUMMY_CYCLES - 1)) begin
            next_state     = SF_TX;
            next_bitcnt    = '0;
            next_req_valid = 1'b1;
          end else if (cmd != CMD_WRAP) begin
            next_bitcnt = bitcnt + 5'd1;
          end
        end
        SF_RX: begin
          if (bitcnt + 5'(step) >= 5'd8) begin
            next_bitcnt = '0;
            rx_byte     = next_shreg;
            rx_push     = cmd != CMD_WR_STATUS;
            if (cmd == CMD_WR_STATUS) begin
              next_req.op    = SFPI_OP_WR_STATUS;
              next_req.addr  = {16'h0000, next_shreg};
              next_req_valid = !(status.status_protect_bits[0] && next_blocks);
              next_state     = SF_IGNORE;
            end
          end
        end
        default: ;
      endcase
    end else if (fall && state == SF_TX) begin
      next_in_w = out_w;
      case (out_w)
        SFPI_W2: begin
          next_lane_out = {2'b00, txbyte[7:6]};
          next_lane_oe  = 4'h3;
          next_txbyte   = {txbyte[5:0], 2'b00};
        end
        SFPI_W4: begin
          next_lane_out = txbyte[7:4];
          next_lane_oe  = 4'hf;
          next_txbyte   = {txbyte[3:0], 4'h0};
        end
        default: begin
          next_lane_out = {2'b00, txbyte[7], 1'b0};
          next_lane_oe  = 4'h2;
          next_txbyte   = {txbyte[6:0], 1'b0};
        end
      endcase
      next_bitcnt = bitcnt + 5'(step);
      if (bitcnt + 5'(step) >= 5'd8) begin
        next_bitcnt  = '0;
        next_tx_load = 1'b1;
      end
    end
    if (tx_load || (state != SF_TX && next_state == SF_TX)) begin
      if (is_uid) begin
        next_txbyte  = UNIQUE_ID[UID_W-1-8*uid_idx[3:0] -: 8];
        next_uid_idx = uid_idx + 7'd1;
      end else begin
        next_txbyte = rd_valid ? rd_data : 8'hff;
      end
    end
    if (next_state == SF_CMD) begin
      next_uid_idx = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= SF_CMD;
      armed    <= 1'b0;
      cs_d     <= 1'b1;
      sclk_d   <= 1'b1;
      shreg    <= '0;
      bitcnt   <= '0;
      cmd      <= '0;
      addr     <= '0;
      in_w     <= SFPI_W1;
      out_w    <= SFPI_W1;
      is_prog  <= 1'b0;
      is_uid   <= 1'b0;
      uid_idx  <= '0;
      txbyte   <= '0;
      tx_load  <= 1'b0;
      lane_out <= '0;
      lane_oe  <= '0;
      req      <= '0;
      req_valid <= 1'b0;
      status_write_refused <= 1'b0;
      protect_pin_blocks   <= 1'b0;
      wrap_len <= '0;
      rd_ready <= 1'b0;
    end else begin
      state    <= next_state;
      armed    <= next_armed;
      cs_d     <= next_cs_d;
      sclk_d   <= sclk_s;
      shreg    <= next_shreg;
      bitcnt   <= next_bitcnt;
      cmd      <= next_cmd;
      addr     <= next_addr;
      in_w     <= next_in_w;
      out_w    <= next_out_w;
      is_prog  <= next_is_prog;
      is_uid   <= next_is_uid;
      uid_idx  <= next_uid_idx;
      txbyte   <= next_txbyte;
      tx_load  <= next_tx_load;
      lane_out <= next_lane_out;
      lane_oe  <= next_lane_oe;
      req      <= next_req;
      req_valid <= next_req_valid;
      status_write_refused <= next_refused;
      protect_pin_blocks   <= next_blocks;
      wrap_len <= next_wrap;
      rd_ready <= (tx_load || (state != SF_TX && next_state == SF_TX)) && !is_uid;
    end
  end

  // ***********************************************************
  // Program data buffer toward the array
  // ***********************************************************
  logic [7:0] fifo_data;
  logic       fifo_valid;

  sfpi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (1'b0),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_valid),
    .out_ready (!wr_valid || wr_ready),
    .out_data  (fifo_data)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
      wr_data  <= '0;
    end else if (!wr_valid || wr_ready) begin
      wr_valid <= fifo_valid;
      wr_data  <= fifo_data;
    end
  end
endmodule

// *** hw/sfpi_pkg.sv ***
// Purpose: Shared constants and carriers for the serial flash pin interface
// Assumes: Byte addresses are 24 bits
// Notes:   Array map, security register map and command codes live here
package sfpi_pkg;

  // ***********************************************************
  // Array organisation
  // ***********************************************************
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned ARRAY_BYTES  = 2097152;
  localparam int unsigned BLOCK_COUNT  = 32;
  localparam int unsigned SECTOR_COUNT = 512;
  localparam int unsigned PAGE_COUNT   = 8192;
  localparam int unsigned SECTOR_LSB   = 12;
  localparam int unsigned BLOCK_LSB    = 16;
  localparam int unsigned PAGE_LSB     = 8;
  localparam logic [23:0] ARRAY_TOP    = 24'h1fffff;

  // ***********************************************************
  // Security registers
  // ***********************************************************
  localparam int unsigned SEC_REG_COUNT = 4;
  localparam logic [11:0] SEC_REG_LOW   = 12'h000;
  localparam logic [11:0] SEC_REG_HIGH  = 12'h0ff;
  localparam int unsigned UID_W         = 128;

  // ***********************************************************
  // Command codes
  // ***********************************************************
  localparam logic [7:0] CMD_READ      = 8'h03;
  localparam logic [7:0] CMD_FAST      = 8'h0b;
  localparam logic [7:0] CMD_DUAL_OUT  = 8'h3b;
  localparam logic [7:0] CMD_QUAD_OUT  = 8'h6b;
  localparam logic [7:0] CMD_DUAL_IO   = 8'hbb;
  localparam logic [7:0] CMD_QUAD_IO   = 8'heb;
  localparam logic [7:0] CMD_PROGRAM   = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROG = 8'h32;
  localparam logic [7:0] CMD_SECT_ERS  = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERS = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERS  = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERS2 = 8'h60;
  localparam logic [7:0] CMD_WR_STATUS = 8'h01;
  localparam logic [7:0] CMD_SEC_READ  = 8'h48;
  localparam logic [7:0] CMD_SEC_PROG  = 8'h42;
  localparam logic [7:0] CMD_SEC_ERS   = 8'h44;
  localparam logic [7:0] CMD_UID_READ  = 8'h4b;
  localparam logic [7:0] CMD_WRAP      = 8'h77;

  localparam int unsigned FAST_DUMMY = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // ***********************************************************
  // Carriers
  // ***********************************************************
  typedef enum logic [1:0] { SFPI_W1, SFPI_W2, SFPI_W4 } sfpi_width_t;

  typedef enum logic [2:0] {
    SFPI_OP_NONE, SFPI_OP_READ, SFPI_OP_PROG, SFPI_OP_ERASE_SEC,
    SFPI_OP_ERASE_BLK, SFPI_OP_ERASE_CHIP, SFPI_OP_WR_STATUS
  } sfpi_op_t;

  typedef struct packed {
    sfpi_op_t    op;
    logic        security;
    logic        uid;
    logic [23:0] addr;
  } sfpi_req_t;

  typedef struct packed {
    logic [2:0] block_protect;
    logic       top_bottom_select;
    logic       small_unit_protect;
    logic       complement_protect;
    logic [1:0] status_protect_bits;
    logic [3:1] lock_bits;
    logic       quad_enable_bit;
  } sfpi_status_t;

endpackage

// *** hw/sfpi_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module sfpi_sync import sfpi_pkg::*; #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule

// *** hw/sfpi_fifo.sv ***
// Purpose: Small FIFO for serial data words
// Assumes: Depth is a power of two
// Notes:   Valid/ready on both sides, honest full and empty
`timescale 1ns/1ps
module sfpi_fifo import sfpi_pkg::*; #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sfpi_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid   = wr_ptr != rd_ptr;
    out_data    = mem[rd_ptr[AW-1:0]];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = flush ? '0 : wr_ptr + (AW+1)'(push);
    next_rd_ptr = flush ? '0 : rd_ptr + (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// *** tb/sfpi_props.sv ***
// Purpose: Port checker for the serial flash pin front end
// Assumes: One clock domain, rstn active low
// Notes:   Bound onto every sfpi_top
`timescale 1ns/1ps
module sfpi_props import sfpi_pkg::*; (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         chip_select_n,
  input wire logic [3:0]   lane_in,
  input wire logic [3:0]   lane_oe,
  input wire sfpi_status_t status,
  input wire logic         array_busy,
  input wire sfpi_req_t    req,
  input wire logic         req_valid,
  input wire logic         protect_pin_blocks,
  input wire logic         status_write_refused,
  input wire logic         rd_ready,
  input wire logic [6:0]   wrap_len
);
  // ***********************************************************
  // Properties
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic pin_low;
  logic paused;
  assign pin_low = !lane_in[2] && !status.quad_enable_bit;
  assign paused  = !lane_in[3] && !status.quad_enable_bit;
  sequence idle_s; chip_select_n [*4]; endsequence
  sequence hold_s; paused [*4]; endsequence
  desel_float_a: assert property (idle_s |-> lane_oe == 4'h0)
    else $error("lanes driven while deselected");
  pause_float_a: assert property (hold_s |-> lane_oe == 4'h0)
    else $error("lanes driven while paused");
  protect_level_a: assert property ($stable(pin_low) [*4] |-> protect_pin_blocks == pin_low)
    else $error("protect level wrong");
  upper_lanes_a: assert property (lane_oe[3:2] != 2'b00 |-> $past(status.quad_enable_bit))
    else $error("upper lanes driven without quad");
  req_pulse_a: assert property (req_valid |=> !req_valid)
    else $error("request longer than one cycle");
  rd_pulse_a: assert property (rd_ready |=> !rd_ready)
    else $error("read take longer than one cycle");
  reset_quiet_a: assert property ($rose(rstn) |-> !req_valid && lane_oe == 4'h0)
    else $error("outputs active at reset release");
  refuse_cause_a: assert property (status_write_refused |->
      protect_pin_blocks && status.status_protect_bits[0] && !req_valid)
    else $error("status write refused without cause");
  busy_guard_a: assert property (req_valid && req.op inside {SFPI_OP_PROG, SFPI_OP_ERASE_SEC,
      SFPI_OP_ERASE_BLK, SFPI_OP_ERASE_CHIP} |-> !$past(array_busy))
    else $error("array request while busy");
  wrap_window_a: assert property (wrap_len inside {7'h00, 7'h08, 7'h10, 7'h20, 7'h40})
    else $error("wrap length not a legal window");
endmodule
bind sfpi_top sfpi_props u_props (.clk, .rstn, .chip_select_n, .lane_in, .lane_oe, .status,
  .array_busy, .req, .req_valid, .protect_pin_blocks, .status_write_refused, .rd_ready,
  .wrap_len);

// *** tb/sfpi_host.sv ***
// Purpose: Behavioural SPI host, clock idles high between frames
// Assumes: clk is 8 ns, serial clock period 64 ns
// Notes:   Drives on serial fall, samples just before the next fall
`timescale 1ns/1ps
module sfpi_host (
  input  wire logic       clk,
  input  wire logic [3:0] pins,
  input  wire logic       wpl,
  output logic            cs_n,
  output logic            sck,
  output logic      [3:0] hout,
  output logic      [3:0] hoe
);
  // ***********************************************************
  // Frame tasks
  // ***********************************************************
  initial begin
    cs_n = 1'b1;
    sck  = 1'b1;
    hout = 4'h0;
    hoe  = 4'h0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  task automatic cyc(input logic d, input logic e);
    sck  <= 1'b0;
    hout <= {1'b1, !wpl, 1'b0, d};
    hoe  <= {1'b0, wpl, 1'b0, e};
    half();
    sck <= 1'b1;
    half();
  endtask
  // Pause with junk clocks that must be ignored
  task automatic pause_blip();
    int j;
    hout[3] <= 1'b0;
    hoe[3]  <= 1'b1;
    half();
    for (j = 0; j < 4; j++) begin
      sck     <= j[0];
      hout[0] <= j[1];
      half();
    end
    hoe[3] <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] a, input int nc, input int na,
      input int nd, input int w, input int nb, input logic [7:0] wb, input logic pz,
      output logic [7:0] got);
    int i;
    logic [7:0] b;
    got = 8'h00;
    cs_n <= 1'b0;
    half();
    for (i = 0; i < nc; i++) cyc(cmd[7-i], 1'b1);
    for (i = 0; i < na; i++) begin
      if (pz && i == 12) pause_blip();
      cyc(a[23-i], 1'b1);
    end
    for (i = 0; i < nd; i++) cyc(1'b0, 1'b0);
    for (i = 0; w == 0 && i < nb * 8; i++) begin
      b = wb + 8'(i / 8);
      cyc(b[7 - i % 8], 1'b1);
    end
    for (i = 0; w > 0 && i < nb * 8 / w; i++) begin
      cyc(1'b0, 1'b0);
      got = (got << w) | (w == 1 ? {7'h00, pins[1]} : 8'(pins & ((4'h1 << w) - 4'h1)));
    end
    cs_n <= 1'b1;
    hoe  <= 4'h0;
    half();
    half();
  endtask
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the serial flash pin front end
// Assumes: Host model drives the pins, bench plays the array side
// Notes:   Requests and program bytes are checked from queues
`timescale 1ns/1ps
module testbench import sfpi_pkg::*; ;
  // ***********************************************************
  // Bench
  // ***********************************************************
  logic         clk, rstn, array_busy, wr_ready, rd_valid, wpl, cs_n, sck;
  logic         req_valid, protect_pin_blocks, status_write_refused, wr_valid, rd_ready;
  logic [3:0]   pins, last, hout, hoe, lane_out, lane_oe;
  logic [7:0]   rd_data, wr_data, got, rdv;
  logic [6:0]   wrap_len;
  logic [23:0]  a;
  sfpi_status_t st;
  sfpi_req_t    req;
  sfpi_req_t    rq[$];
  logic [7:0]   wq[$];
  int           bad_count, n_tests, nref, i;
  logic [7:0]   rcmd[3] = '{CMD_FAST, CMD_DUAL_OUT, CMD_QUAD_OUT};
  logic [7:0]   ecmd[4] = '{CMD_SECT_ERS, CMD_BLOCK_ERS, CMD_CHIP_ERS, CMD_CHIP_ERS2};
  sfpi_op_t     eop[4]  = '{SFPI_OP_ERASE_SEC, SFPI_OP_ERASE_BLK, SFPI_OP_ERASE_CHIP,
                            SFPI_OP_ERASE_CHIP};
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  sfpi_top #(.DUMMY_CYCLES(8)) u_dut (.clk(clk), .rstn(rstn), .chip_select_n(cs_n),
    .serial_clock(sck), .lane_in(pins), .lane_out(lane_out), .lane_oe(lane_oe), .status(st),
    .array_busy(array_busy), .req(req), .req_valid(req_valid),
    .protect_pin_blocks(protect_pin_blocks), .status_write_refused(status_write_refused),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .wrap_len(wrap_len));
  sfpi_host u_host (.clk(clk), .pins(pins), .wpl(wpl), .cs_n(cs_n), .sck(sck), .hout(hout),
    .hoe(hoe));
  // Undriven lanes 2 and 3 pull up, lanes 0 and 1 show the inverse of the last level
  always_comb for (int k = 0; k < 4; k++)
    pins[k] = lane_oe[k] ? lane_out[k] : hoe[k] ? hout[k] : (k > 1) | ~last[k];
  always_ff @(posedge clk) last <= rstn ? pins : 4'h0;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic sfpi_req_t msk(sfpi_req_t r);
    if (r.op inside {SFPI_OP_ERASE_CHIP, SFPI_OP_WR_STATUS}) r.addr = 24'h0;
    return r;
  endfunction
  task automatic e(input sfpi_op_t op, input logic s, input logic [23:0] ad);
    rq.push_back('{op, s, 1'b0, ad});
  endtask
  always @(posedge clk) begin
    if (req_valid === 1'b1) begin
      if (rq.size() == 0) chk("req_extra", 1, 0);
      else chk("req", 32'(msk(req)), 32'(msk(rq.pop_front())));
    end
    if (wr_valid === 1'b1 && wr_ready && wq.size() > 0)
      chk("wr_data", 32'(wr_data), 32'(wq.pop_front()));
    if (status_write_refused === 1'b1) nref++;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300us;
    bad_count++;
    summarize();
  end
  initial begin
    rstn = 1'b0; array_busy = 1'b0; wr_ready = 1'b1; rd_valid = 1'b1; rd_data = 8'h00;
    wpl = 1'b0; st = '0; bad_count = 0; n_tests = 0; nref = 0;
    void'($urandom(52));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    u_host.xfer(CMD_WRAP, 24'h0, 8, 0, 0, 0, 1, 8'h40, 1'b0, got);
    chk("wrap", 32'(wrap_len), 32'd32);
    u_host.xfer(CMD_READ, 24'h000000, 4, 0, 0, 0, 0, 8'h00, 1'b0, got);
    rdv = 8'($urandom);
    rd_data <= rdv;
    a = 24'($urandom) & ARRAY_TOP;
    e(SFPI_OP_READ, 1'b0, a);
    u_host.xfer(CMD_READ, a, 8, 24, 0, 1, 2, 8'h00, 1'b1, got);
    chk("rd_single", 32'(got), 32'(rdv));
    for (i = 0; i < 3; i++) begin
      st.quad_enable_bit <= (i == 2);
      rdv = 8'($urandom);
      rd_data <= rdv;
      a = 24'($urandom) & ARRAY_TOP;
      e(SFPI_OP_READ, 1'b0, a);
      u_host.xfer(rcmd[i], a, 8, 24, 8, 1 << i, 1, 8'h00, 1'b0, got);
      chk("rd_wide", 32'(got), 32'(rdv));
    end
    st.quad_enable_bit <= 1'b0;
    for (i = 0; i < 4; i++) begin
      a = 24'($urandom) & ARRAY_TOP & ((i > 0) ? 24'hff0000 : 24'hfff000);
      e(eop[i], 1'b0, a);
      u_host.xfer(ecmd[i], a, 8, (i < 2) ? 24 : 0, 0, 0, 0, 8'h00, 1'b0, got);
    end
    array_busy <= 1'b1;
    u_host.xfer(CMD_SECT_ERS, 24'h010000, 8, 24, 0, 0, 0, 8'h00, 1'b0, got);
    array_busy <= 1'b0;
    rdv = 8'($urandom);
    rd_data <= rdv;
    a = 24'h002000 | 24'(8'($urandom));
    e(SFPI_OP_READ, 1'b1, a);
    u_host.xfer(CMD_SEC_READ, a, 8, 24, 8, 1, 1, 8'h00, 1'b0, got);
    chk("rd_security", 32'(got), 32'(rdv));
    wr_ready <= 1'b0;
    a = 24'($urandom) & 24'h1fff00;
    e(SFPI_OP_PROG, 1'b0, a);
    for (i = 0; i < 8; i++) wq.push_back(8'h5a + 8'(i));
    u_host.xfer(CMD_PROGRAM, a, 8, 24, 0, 0, 10, 8'h5a, 1'b0, got);
    wr_ready <= 1'b1;
    repeat (40) @(posedge clk);
    wpl <= 1'b1;
    st.status_protect_bits <= 2'b01;
    u_host.xfer(CMD_WR_STATUS, 24'h0, 8, 0, 0, 0, 1, 8'h00, 1'b0, got);
    wpl <= 1'b0;
    e(SFPI_OP_WR_STATUS, 1'b0, 24'h0);
    u_host.xfer(CMD_WR_STATUS, 24'h0, 8, 0, 0, 0, 1, 8'h00, 1'b0, got);
    chk("refused", 32'(nref), 32'd1);
    chk("left", 32'(rq.size()), 32'd0);
    summarize();
  end
endmodule
